//--- bench/sscs_drv_model.sv
// Purpose: behaviour of the three half-bridge gate driver
// Assumes: oe_i high enables outputs
// Notes: OE low blanks at once, no 1 ms filter
`timescale 1ns/100ps
`default_nettype none
module sscs_drv_model (
  input wire logic oe_i,
  input wire logic [2:0] hi_cmd_i,
  input wire logic [2:0] lo_cmd_i,
  output logic [2:0] hi_gate_o,
  output logic [2:0] lo_gate_o
);
  // High command turns a gate on; a leg conflict turns both off
  assign hi_gate_o = {3{oe_i}} & hi_cmd_i & ~lo_cmd_i;
  assign lo_gate_o = {3{oe_i}} & lo_cmd_i & ~hi_cmd_i;
endmodule // sscs_drv_model
`default_nettype wire

//--- bench/sscs_seq_properties.sv
// Purpose: timing checks on sequencer outputs
// Assumes: gates active high, mode_o one-hot
// Notes: hi and lo are phases c,b,a
`timescale 1ns/100ps
`default_nettype none
module sscs_seq_chk (
  input wire mclk_i,
  input wire rstn_i,
  input wire start_i,
  input wire high_gate_phase_a_o,
  input wire high_gate_phase_b_o,
  input wire high_gate_phase_c_o,
  input wire low_gate_phase_a_o,
  input wire low_gate_phase_b_o,
  input wire low_gate_phase_c_o,
  input wire driver_enable_o,
  input wire bemf_enable_o,
  input wire [4:0] mode_o
);
  wire [2:0] hi = {high_gate_phase_c_o, high_gate_phase_b_o, high_gate_phase_a_o};
  wire [2:0] lo = {low_gate_phase_c_o, low_gate_phase_b_o, low_gate_phase_a_o};
  // One domain, so clock and reset are shared by all
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_adv; $changed(mode_o) && mode_o != 5'h01; endsequence
  property p_order; s_adv |-> mode_o == {$past(mode_o[3:0]), 1'b0}; endproperty
  a_order: assert property (p_order) else $error("mode order");
  property p_dis; mode_o == 5'h01 |-> !driver_enable_o && hi == 3'h0 && lo == 3'h0; endproperty
  a_dis: assert property (p_dis) else $error("idle gates");
  property p_boot; mode_o == 5'h02 |-> hi == 3'h0 && lo == 3'h7; endproperty
  a_boot: assert property (p_boot) else $error("boot gates");
  property p_lock; mode_o == 5'h04 |-> hi == 3'h5 && lo == 3'h2; endproperty
  a_lock: assert property (p_lock) else $error("lock gates");
  property p_pair; (hi & lo) == 3'h0; endproperty
  a_pair: assert property (p_pair) else $error("leg overlap");
  property p_ramp; mode_o == 5'h08 |-> $onehot(lo) && $onehot0(hi); endproperty
  a_ramp: assert property (p_ramp) else $error("ramp pair");
  property p_stop; !start_i |-> ##[1:2] mode_o == 5'h01; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_bemf; bemf_enable_o == (mode_o == 5'h10); endproperty
  a_bemf: assert property (p_bemf) else $error("sense enable");
endmodule // sscs_seq_chk
bind sscs_sequencer sscs_seq_chk i_sscs_seq_chk (.mclk_i, .rstn_i, .start_i,
  .high_gate_phase_a_o, .high_gate_phase_b_o, .high_gate_phase_c_o, .low_gate_phase_a_o,
  .low_gate_phase_b_o, .low_gate_phase_c_o, .driver_enable_o, .bemf_enable_o, .mode_o);
`default_nettype wire

//--- bench/sscs_sequencer_tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: short lock and ramp counts
// Notes: inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
`include "sscs_defs.vh"
module sscs_sequencer_tb;
  logic mclk_i, rstn_i, start_i, dir_rev_i, zero_cross_i;
  logic oc_i;
  logic [1:0] fm_i;
  logic [7:0] meas_i;
  wire [2:0] hi, lo, hg, lg;
  wire [1:0] bph;
  wire [4:0] mode;
  wire den, ben, sd;
  int err_total, checked, n;
  // Short counts keep the run far under the cycle budget
  sscs_sequencer #(.LOCK_CYC(20), .RAMP_START(50), .RAMP_DEC(10), .RAMP_END(10))
    i_sscs_sequencer (.mclk_i(mclk_i), .rstn_i(rstn_i), .start_i(start_i),
    .dir_rev_i(dir_rev_i), .speed_cmd_i(8'h80), .speed_meas_i(meas_i), .fast_method_i(fm_i),
    .overcurrent_i(oc_i), .zero_cross_i(zero_cross_i), .high_gate_phase_a_o(hi[0]),
    .high_gate_phase_b_o(hi[1]), .high_gate_phase_c_o(hi[2]), .low_gate_phase_a_o(lo[0]),
    .low_gate_phase_b_o(lo[1]), .low_gate_phase_c_o(lo[2]), .driver_enable_o(den),
    .bemf_phase_o(bph), .bemf_enable_o(ben), .slow_decay_o(sd), .mode_o(mode));
  sscs_drv_model i_sscs_drv_model (.oe_i(den), .hi_cmd_i(hi), .lo_cmd_i(lo),
    .hi_gate_o(hg), .lo_gate_o(lg));
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checked++;
    if (got !== ex)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] step_of(input logic [5:0] v);
    case (v)
      6'h0C: return 8'h01;
      6'h14: return 8'h02;
      6'h11: return 8'h03;
      6'h21: return 8'h04;
      6'h22: return 8'h05;
      6'h0A: return 8'h06;
      default: return 8'h00;
    endcase
  endfunction
  // Bounded waits; PWM may blank the high gate for a while
  task automatic wait_mode(input logic [4:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk("mode", {3'h0, m}, {3'h0, mode});
    if (mode !== m)
      print_verdict();
  endtask
  task automatic get_step(output logic [7:0] s);
    n = 0;
    s = step_of({hi, lo});
    while (s === 8'h00 && n < 300)
    begin
      @(negedge mclk_i);
      s = step_of({hi, lo});
      n++;
    end
  endtask
  task automatic t_start;
    chk("idle", 8'h00, {2'h0, hg, lg});
    start_i = 1'b1;
    wait_mode(5'h02, 4);
    @(negedge mclk_i);
    chk("boot", 8'h07, {2'h0, hg, lg});
    wait_mode(5'h04, 49000);
    chk("boot_len", 8'h01, 8'(n >= 47990));
    @(negedge mclk_i);
    chk("lock", 8'h2A, {2'h0, hg, lg});
    wait_mode(5'h08, 40);
    chk("lock_len", 8'h01, 8'(n >= 18));
  endtask
  // Step periods 50, 40, 30, 20 with the short counts, then run
  task automatic t_ramp;
    logic [7:0] p, s;
    int c, k, lc, pv;
    p = 8'h00;
    c = 0;
    k = 0;
    lc = 0;
    pv = 0;
    while (mode === 5'h08 && c < 300)
    begin
      s = step_of({hi, lo});
      if (s !== 8'h00 && s !== p)
      begin
        if (p !== 8'h00)
        begin
          chk("ramp_step", p == 8'h06 ? 8'h01 : p + 8'h01, s);
          chk("ramp_period", pv == 0 ? 8'h32 : 8'(pv - 10), 8'(c - lc));
          pv = c - lc;
        end
        p = s;
        lc = c;
        k++;
      end
      @(negedge mclk_i);
      c++;
    end
    chk("ramp_steps", 8'h04, 8'(k));
    chk("run", 8'h11, {3'h0, mode} | {7'h00, ben});
  endtask
  task automatic t_run;
    logic [7:0] p, s, e;
    int d;
    for (d = 0; d < 2; d++)
    begin
      dir_rev_i = d[0];
      repeat (3)
      begin
        get_step(p);
        zero_cross_i = 1'b1;
        @(negedge mclk_i);
        zero_cross_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        get_step(s);
        e = d ? (p == 8'h01 ? 8'h06 : p - 8'h01) : (p == 8'h06 ? 8'h01 : p + 8'h01);
        chk("run_step", e, s);
        e = (s == 8'h01 || s == 8'h04) ? 8'h01 : (s == 8'h02 || s == 8'h05) ? 8'h00 : 8'h02;
        chk("bemf", e, {6'h00, bph});
      end
    end
  endtask
  // Overcurrent cut, average duty, then slow decay when speed holds
  task automatic t_pwm;
    int h, l;
    logic [2:0] s0;
    oc_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk("oc_high", 8'h00, {5'h00, hi});
    chk("oc_low", 8'h01, 8'($onehot(lo)));
    oc_i = 1'b0;
    fm_i = 2'h2;
    repeat (2) @(negedge mclk_i);
    h = 0;
    repeat (256)
    begin
      @(negedge mclk_i);
      h = h + (hi != 3'h0);
    end
    chk("avg_duty", 8'((16'h0080 * `SSCS_FAST_SCALE_NUM) >> `SSCS_FAST_SCALE_SHIFT), 8'(h));
    chk("fast_mode", 8'h00, {7'h00, sd});
    fm_i = 2'h0;
    meas_i = 8'h80;
    repeat (300) @(negedge mclk_i);
    chk("slow_on", 8'h01, {7'h00, sd});
    h = 0;
    l = 0;
    s0 = lo;
    repeat (255)
    begin
      @(negedge mclk_i);
      h = h + (hi != 3'h0);
      l = l + (lo === s0);
    end
    chk("slow_low", 8'hFF, 8'(l));
    chk("slow_chop", 8'h01, 8'(h < 255));
    meas_i = 8'h00;
    repeat (2) @(negedge mclk_i);
    chk("slow_off", 8'h00, {7'h00, sd});
  endtask
  task automatic t_restart;
    start_i = 1'b0;
    wait_mode(5'h01, 4);
    chk("off", 8'h00, {2'h0, hg, lg});
    start_i = 1'b1;
    wait_mode(5'h02, 4);
    rstn_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk("rst_mode", 8'h01, {3'h0, mode});
    chk("rst_gates", 8'h00, {2'h0, hi, lo});
    rstn_i = 1'b1;
    wait_mode(5'h02, 4);
  endtask
  // Clock at 40 MHz
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Reset, then the scenarios in order
  initial
  begin
    rstn_i = 1'b0;
    start_i = 1'b0;
    dir_rev_i = 1'b0;
    zero_cross_i = 1'b0;
    oc_i = 1'b0;
    fm_i = 2'h0;
    meas_i = 8'h00;
    err_total = 0;
    checked = 0;
    repeat (20) @(negedge mclk_i);
    rstn_i = 1'b1;
    @(negedge mclk_i);
    t_start;
    t_ramp;
    t_run;
    t_pwm;
    t_restart;
    print_verdict();
  end
endmodule // sscs_sequencer_tb
`default_nettype wire

//--- include/sscs_defs.vh
// Purpose: constants for the six-step commutation sequencer
// Assumes: 40 MHz mclk_i
// Notes: boot time in its own unit with its cycle count derived; lock and ramp counts given in cycles, slow divider in PWM periods
`ifndef SSCS_DEFS_VH
`define SSCS_DEFS_VH
`define SSCS_CLK_MHZ 40
`define SSCS_BOOT_US_PER_UF 1200
`define SSCS_BOOT_CYC_PER_UF (`SSCS_BOOT_US_PER_UF * `SSCS_CLK_MHZ)
`define SSCS_FAST_SCALE_NUM 8'hE9
`define SSCS_FAST_SCALE_SHIFT 8
`define SSCS_PWM_W 8
`define SSCS_STEP_MIN 1
`define SSCS_STEP_MAX 6
`define SSCS_LOCK_CYC 32'h003D0900
`define SSCS_RAMP_START 32'h00061A80
`define SSCS_RAMP_DEC 32'h000007D0
`define SSCS_RAMP_END 32'h00009C40
`define SSCS_SLOW_DIV 32'h00000010
`endif

//--- logic/sscs_sequencer.v
// Purpose: host-side six-step sensorless start-up and run sequencer
// Assumes: gate driver inputs active high; all inputs synchronous to mclk_i
// Notes: PLL and speed loop are simplified; zero-cross input advances run steps
// Notes: start_i low acts as the disable input; it forces the disabled mode
//   and every later start walks the whole sequence again from bootstrap
// Notes: bootstrap length is fixed at build time by BOOT_UF; size it for the
//   largest bootstrap capacitor, since too short leaves the high side weak
// Notes: slow decay needs a stable measured speed for one full PWM period
//
// How it works
// - two windings driven, six steps, one floats
// - disabled, bootstrap, lock, ramp, run in order
// - ascending or descending steps select direction
// - bootstrap turns all low gates on
// - bootstrap time scales per microfarad, programmable
// - lock drives A and C high, B low
// - lock holds for configured settle interval
// - ramp steps open-loop, step period falls linearly
// - run uses back-EMF tracking and speed loop
// - fixed gate pair for each of six states
// - sample floating phase B, A or C per state
// - fast-decay and slow-decay PWM both supported
// - fast decay while accelerating, slow when steady in run
// - fast loop: hysteretic, off-time or average current
// - fast-decay command about nine percent lower
// - slow decay chops high side, low stays on
// - slow loop bandwidth below fast loop
`timescale 1ns/100ps
`default_nettype none
`include "sscs_defs.vh"
module sscs_sequencer #(
  parameter BOOT_UF = 1,
  parameter LOCK_CYC = `SSCS_LOCK_CYC,
  parameter RAMP_START = `SSCS_RAMP_START,
  parameter RAMP_DEC = `SSCS_RAMP_DEC,
  parameter RAMP_END = `SSCS_RAMP_END,
  parameter SLOW_DIV = `SSCS_SLOW_DIV
)(
  input wire mclk_i,
  input wire rstn_i,
  input wire start_i,
  input wire dir_rev_i,
  input wire [7:0] speed_cmd_i,
  input wire [7:0] speed_meas_i,
  input wire [1:0] fast_method_i,
  input wire overcurrent_i,
  input wire zero_cross_i,
  output reg high_gate_phase_a_o,
  output reg high_gate_phase_b_o,
  output reg high_gate_phase_c_o,
  output reg low_gate_phase_a_o,
  output reg low_gate_phase_b_o,
  output reg low_gate_phase_c_o,
  output reg driver_enable_o,
  output reg [1:0] bemf_phase_o,
  output reg bemf_enable_o,
  output reg slow_decay_o,
  output reg [4:0] mode_o
);
  localparam [4:0] ST_DIS = 5'h01;
  localparam [4:0] ST_BOOT = 5'h02;
  localparam [4:0] ST_LOCK = 5'h04;
  localparam [4:0] ST_RAMP = 5'h08;
  localparam [4:0] ST_RUN = 5'h10;
  localparam [31:0] BOOT_CYC = `SSCS_BOOT_CYC_PER_UF * BOOT_UF;
  localparam [31:0] LOCK_LEN = LOCK_CYC;
  localparam [31:0] RAMP_ST = RAMP_START;
  localparam [31:0] RAMP_D = RAMP_DEC;
  localparam [31:0] RAMP_E = RAMP_END;
  // Slow divider count kept to the width of its counter on purpose
  localparam [31:0] SLOW_W = SLOW_DIV;
  localparam [7:0] SLOW_D = SLOW_W[7:0];

  // Mode, shared timer, ramp step period and commutation step
  reg [4:0] state_r;
  reg [31:0] tmr_r;
  reg [31:0] period_r;
  reg [2:0] step_r;
  // PWM carrier, slow-loop divider and duty, last measured speed
  reg [7:0] pwm_cnt_r;
  reg [7:0] slow_div_r;
  reg [7:0] slow_duty_r;
  reg [7:0] prev_meas_r;
  reg chop_on_r;
  // Fast-loop command and acceleration flag
  wire [15:0] fast_prod;
  wire [7:0] fast_cmd;
  wire accel;
  reg [2:0] step_nxt;
  reg hi_on;
  reg [5:0] gates;
  reg [5:0] safe_gates;

  // Command for fast loop scaled by 233/256, about nine percent lower
  assign fast_prod = speed_cmd_i * `SSCS_FAST_SCALE_NUM;
  assign fast_cmd = fast_prod[15:8];
  // Acceleration when speed changed or still short of command
  assign accel = (speed_meas_i != prev_meas_r) || (speed_meas_i < fast_cmd);

  // Next step in chosen direction with wrap
  always @*
  begin
    if (dir_rev_i)
      step_nxt = (step_r == 3'h1) ? 3'h6 : step_r - 3'h1;
    else
      step_nxt = (step_r == 3'h6) ? 3'h1 : step_r + 3'h1;
  end

  // Mode sequencer
  always @(posedge mclk_i)
  begin
    if (!rstn_i || !start_i)
    begin
      state_r <= ST_DIS;
      tmr_r <= 32'h0;
      period_r <= 32'h0;
      step_r <= 3'h1;
    end
    else
    begin
      case (state_r)
        // Leave disabled on the first enabled edge
        ST_DIS:
        begin
          state_r <= ST_BOOT;
          tmr_r <= 32'h0;
        end
        // Charge the bootstraps for the programmed number of cycles
        ST_BOOT:
        begin
          tmr_r <= tmr_r + 32'h1;
          if (tmr_r >= BOOT_CYC - 32'h1)
          begin
            state_r <= ST_LOCK;
            tmr_r <= 32'h0;
          end
        end
        // Hold the alignment pattern, then load the first ramp period
        ST_LOCK:
        begin
          tmr_r <= tmr_r + 32'h1;
          if (tmr_r >= LOCK_LEN - 32'h1)
          begin
            state_r <= ST_RAMP;
            tmr_r <= 32'h0;
            // Ramp restarts at step one, the step the rotor was parked ahead of
            period_r <= RAMP_ST;
            step_r <= 3'h1;
          end
        end
        // Each period one decrement shorter: the step period falls linearly
        ST_RAMP:
        begin
          tmr_r <= tmr_r + 32'h1;
          if (tmr_r >= period_r - 32'h1)
          begin
            tmr_r <= 32'h0;
            step_r <= step_nxt;
            if (period_r <= RAMP_E + RAMP_D)
              state_r <= ST_RUN;
            else
              period_r <= period_r - RAMP_D;
          end
        end
        ST_RUN:
        begin
          // Zero-cross from the back-EMF tracker paces commutation
          if (zero_cross_i)
            step_r <= step_nxt;
        end
        // An illegal one-hot code falls back to disabled
        default:
          state_r <= ST_DIS;
      endcase
    end
  end

  // PWM counters; slow loop updates duty only every SLOW_DIV periods
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      pwm_cnt_r <= 8'h00;
      slow_div_r <= 8'h00;
      slow_duty_r <= 8'h00;
      prev_meas_r <= 8'h00;
      chop_on_r <= 1'b0;
    end
    else
    begin
      // Free-running 8-bit carrier, 256 cycles per PWM period
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
      if (pwm_cnt_r == 8'hFF)
      begin
        prev_meas_r <= speed_meas_i;
        slow_div_r <= (slow_div_r >= SLOW_D - 8'h01) ? 8'h00 : slow_div_r + 8'h01;
        // Slower duty update than fast loop keeps transients in fast loop
        if (slow_div_r == 8'h00)
        begin
          if (speed_meas_i < speed_cmd_i && slow_duty_r != 8'hFF)
            slow_duty_r <= slow_duty_r + 8'h01;
          else if (speed_meas_i > speed_cmd_i && slow_duty_r != 8'h00)
            slow_duty_r <= slow_duty_r - 8'h01;
        end
      end
      // Fast loop current regulation method, chosen by fast_method_i
      // 0: hysteretic, off on overcurrent and straight back on when it clears
      // 1: fixed off-time, off on overcurrent until the next 64-cycle boundary
      // 2,3: average, duty follows the reduced command, overcurrent still cuts
      case (fast_method_i)
        2'h0: chop_on_r <= overcurrent_i ? 1'b0 : 1'b1;
        2'h1: chop_on_r <= overcurrent_i ? 1'b0 : (pwm_cnt_r[5:0] == 6'h3F) ? 1'b1 : chop_on_r;
        default: chop_on_r <= (pwm_cnt_r < fast_cmd) && !overcurrent_i;
      endcase
    end
  end

  // Gate pattern per mode and step.
  // The high gate of the active pair carries the PWM and the low gate stays
  // on for the whole step, so in slow decay the winding current coasts through
  // the low switch and its partner's body diode instead of fighting the supply.
  // Fast decay uses the same pattern but takes its chop flag from the fast loop.
  always @*
  begin
    hi_on = slow_decay_nxt(1'b0) ? (pwm_cnt_r < slow_duty_r) : chop_on_r;
    gates = 6'h00;
    case (state_r)
      // All lows on pulls every phase node down and charges the bootstraps
      ST_BOOT: gates = 6'b000111;
      // A and C high against B low parks the rotor ahead of step one
      ST_LOCK: gates = 6'b101010;
      ST_RAMP, ST_RUN:
      begin
        // Order: high A,B,C then low A,B,C
        // Every step drives one high and one low gate and leaves a phase free
        case (step_r)
          3'h1:
          begin
            // A high, C low, B floats
            gates = {hi_on, 2'b00, 3'b001};
          end
          3'h2:
          begin
            // B high, C low, A floats
            gates = {1'b0, hi_on, 1'b0, 3'b001};
          end
          3'h3:
          begin
            // B high, A low, C floats
            gates = {1'b0, hi_on, 1'b0, 3'b100};
          end
          3'h4:
          begin
            // C high, A low, B floats
            gates = {2'b00, hi_on, 3'b100};
          end
          3'h5:
          begin
            // C high, B low, A floats
            gates = {2'b00, hi_on, 3'b010};
          end
          3'h6:
          begin
            // A high, B low, C floats
            gates = {hi_on, 2'b00, 3'b010};
          end
          default:
          begin
            // Steps zero and seven never occur; drive nothing
            gates = 6'h00;
          end
        endcase
      end
      default:
      begin
        // Disabled or corrupt state: every gate off
        gates = 6'h00;
      end
    endcase
  end

  // Leg guard: one phase never gets both commands in the same cycle.
  // The step table never asks for that; the guard only covers a corrupted
  // state or step register, where a shoot-through would cost the bridge.
  always @*
  begin
    safe_gates[5] = gates[5] & ~gates[2];
    safe_gates[4] = gates[4] & ~gates[1];
    safe_gates[3] = gates[3] & ~gates[0];
    safe_gates[2] = gates[2] & ~gates[5];
    safe_gates[1] = gates[1] & ~gates[4];
    safe_gates[0] = gates[0] & ~gates[3];
  end

  // Slow decay only when steady in run mode.
  // Any change of measured speed, or a speed still short of the reduced
  // command, counts as acceleration and keeps the fast loop in charge.
  // The argument is unused; plain Verilog needs a function to have an input.
  function slow_decay_nxt;
    input dummy;
    begin
      slow_decay_nxt = (state_r == ST_RUN) && !accel;
    end
  endfunction

  // Registered gate commands; in ramp and run one winding is left floating.
  // Registering delays the pins one cycle after the state, but keeps every
  // pin glitch-free, which matters because the driver acts on any pulse.
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      {high_gate_phase_a_o, high_gate_phase_b_o, high_gate_phase_c_o} <= 3'b000;
      {low_gate_phase_a_o, low_gate_phase_b_o, low_gate_phase_c_o} <= 3'b000;
    end
    else
    begin
      {high_gate_phase_a_o, high_gate_phase_b_o, high_gate_phase_c_o} <= safe_gates[5:3];
      {low_gate_phase_a_o, low_gate_phase_b_o, low_gate_phase_c_o} <= safe_gates[2:0];
    end
  end

  // Registered status: enable, mode, sensing and decay flags.
  // driver_enable_o drops on the same edge that start_i is seen low, one
  // cycle before the gates are cleared, so the driver blanks first.
  always @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      driver_enable_o <= 1'b0;
      bemf_phase_o <= 2'h0;
      bemf_enable_o <= 1'b0;
      slow_decay_o <= 1'b0;
      mode_o <= ST_DIS;
    end
    else
    begin
      driver_enable_o <= start_i && (state_r != ST_DIS);
      mode_o <= state_r;
      bemf_enable_o <= (state_r == ST_RUN);
      slow_decay_o <= slow_decay_nxt(1'b0);
      // Floating phase: 0=A 1=B 2=C
      case (step_r)
        // Steps one and four leave B free
        3'h1, 3'h4: bemf_phase_o <= 2'h1;
        // Steps two and five leave A free
        3'h2, 3'h5: bemf_phase_o <= 2'h0;
        // Steps three and six leave C free
        default: bemf_phase_o <= 2'h2;
      endcase
    end
  end
endmodule // sscs_sequencer
`default_nettype wire
